// >>> rtl/stream_source_pkg.sv
// Constants and types shared by the stream source driver and its testbench.
package stream_source_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_ARG = 8'h00;
  localparam logic [7:0] OFF_CALL = 8'h04;
  localparam logic [7:0] OFF_RET = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_CONFIG = 8'h14;

  // Function codes written to the call register.
  localparam logic [3:0] CMD_INITIALISE = 4'h0;
  localparam logic [3:0] CMD_SET_BACKPRESSURE_TIMEOUT = 4'h1;
  localparam logic [3:0] CMD_QUEUE_TRANSACTION = 4'h2;
  localparam logic [3:0] CMD_READ_OUTGOING_DEPTH = 4'h3;
  localparam logic [3:0] CMD_READ_RESPONSE_DEPTH = 4'h4;
  localparam logic [3:0] CMD_SET_BEAT_PAYLOAD = 4'h5;
  localparam logic [3:0] CMD_SET_BEAT_CHANNEL = 4'h6;
  localparam logic [3:0] CMD_SET_LEADING_IDLES = 4'h7;
  localparam logic [3:0] CMD_SET_PACKET_FIRST = 4'h8;
  localparam logic [3:0] CMD_SET_PACKET_LAST = 4'h9;
  localparam logic [3:0] CMD_SET_BEAT_ERROR = 4'hA;
  localparam logic [3:0] CMD_SET_UNUSED_SYMBOLS = 4'hB;
  localparam logic [3:0] CMD_TAKE_RESPONSE = 4'hC;
  localparam logic [3:0] CMD_READ_STALL_CYCLES = 4'hD;
  localparam logic [3:0] CMD_READ_READY_STATE = 4'hE;
  localparam logic [3:0] CMD_READ_ALL_DONE = 4'hF;

  // Interrupt status and mask bit positions.
  localparam int IRQ_DRIVE = 0;
  localparam int IRQ_RESP = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_FATAL = 3;
  localparam int IRQ_W = 4;

  // Config register: bit 0 selects a sink ready latency above zero.
  localparam int CFG_LATENCY_BIT = 0;

  localparam int QUEUE_DEPTH = 8;
  localparam int COUNT_W = 4;
  localparam int STALL_W = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DRIVE, ST_HALT} drv_state_e;

  // One queued transaction: beat fields plus its leading idle count.
  typedef struct packed {
    logic [15:0] idles;
    logic error;
    logic [1:0] empty;
    logic eop;
    logic sop;
    logic channel;
    logic [31:0] data;
  } txn_s;

endpackage

// >>> rtl/stream_queue.sv
// Synchronous first-in first-out queue with valid/ready on both sides.
module stream_queue #(
  parameter int W = 8,
  parameter int D = 8,
  parameter int CW = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  // Filling side
  input wire logic push_valid_in,
  output logic push_ready_out,
  input wire logic [W-1:0] push_data_in,
  // Draining side
  output logic pop_valid_out,
  input wire logic pop_ready_in,
  output logic [W-1:0] pop_data_out,
  output logic [CW-1:0] count_out
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [CW-1:0] cnt;
  } queue_s;

  queue_s q;
  queue_s d;
  logic push;
  logic pop;

  assign push_ready_out = q.cnt != CW'(D);
  assign pop_valid_out = q.cnt != '0;
  assign pop_data_out = q.mem[q.rd];
  assign count_out = q.cnt;

  always_comb begin
    d = q;
    push = push_valid_in && push_ready_out;
    pop = pop_ready_in && pop_valid_out;
    if (push) begin
      d.mem[q.wr] = push_data_in;
      d.wr = q.wr + AW'(1);
    end
    if (pop) begin
      d.rd = q.rd + AW'(1);
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
    if (clear_in) begin
      d.rd = '0;
      d.wr = '0;
      d.cnt = '0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// >>> rtl/stream_source_driver.sv
// Stream source driver: queued transactions driven beat by beat to a sink.
// Operation
// RL1 - Queue command appends transaction; driver drives queue.
// RL2 - Backpressure timeout count; zero disables it.
// RL3 - Leading idle cycles precede each driven transaction.
// RL4 - Initialise puts stream outputs into idle.
// RL5 - Beat fields assembled, then driven with beat.
// RL6 - Host takes response before reading its contents.
// RL7 - Response-done event once response is queued.
// RL8 - Driving event when beat presentation starts.
// RL9 - Completion event when outgoing queue drained.
// RL10 - Fatal error raises event, halts all operation.
// RL11 - Command port kept apart from stream timing.
// RL12 - Each operation selected by fixed function code.
// RL13 - Illegal field contents driven unchanged, never refused.
// RL14 - Zero ready latency: hold beat until ready.
// RL15 - Nonzero latency: idle until ready, then drive.
// RL16 - Stall cycles recorded as transaction response latency.
// RL17 - Transactions and responses handled first in, first out.
module stream_source_driver
  import stream_source_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Stream toward the sink
  output logic str_valid_out,
  output logic [31:0] str_data_out,
  output logic str_channel_out,
  output logic str_sop_out,
  output logic str_eop_out,
  output logic [1:0] str_empty_out,
  output logic str_error_out,
  input wire logic str_ready_in,
  // Interrupt
  output logic irq_out
);

  typedef struct packed {
    drv_state_e st;
    logic valid;
    txn_s cur;
    txn_s asm_t;
    logic [15:0] cnt;
    logic [STALL_W-1:0] stall;
    logic [STALL_W-1:0] last_stall;
    logic [15:0] tmo;
    logic latency;
    logic all_done;
    logic drv_pulse;
    logic [31:0] arg;
    logic [31:0] ret;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mk;
    logic irq;
    logic wr_pend;
    logic rd_pend;
    logic hit;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } drv_s;

  drv_s q;
  drv_s d;
  logic [IRQ_W-1:0] ev;
  logic clr;
  logic o_push;
  logic o_rdy;
  logic o_vld;
  logic o_pop;
  txn_s o_data;
  logic [COUNT_W-1:0] o_cnt;
  logic r_push;
  logic r_rdy;
  logic r_vld;
  logic r_pop;
  logic [STALL_W-1:0] r_data;
  logic [COUNT_W-1:0] r_cnt;
  logic beat_done;

  // Outgoing transaction queue.
  stream_queue #(.W($bits(txn_s)), .D(QUEUE_DEPTH), .CW(COUNT_W)) u_out (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(clr),
    .push_valid_in(o_push),
    .push_ready_out(o_rdy),
    .push_data_in(q.asm_t),
    .pop_valid_out(o_vld),
    .pop_ready_in(o_pop),
    .pop_data_out(o_data),
    .count_out(o_cnt)
  );

  // Response queue holding the stall count of each finished beat.
  stream_queue #(.W(STALL_W), .D(QUEUE_DEPTH), .CW(COUNT_W)) u_resp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(clr),
    .push_valid_in(r_push),
    .push_ready_out(r_rdy),
    .push_data_in(q.stall),
    .pop_valid_out(r_vld),
    .pop_ready_in(r_pop),
    .pop_data_out(r_data),
    .count_out(r_cnt)
  );

  always_comb begin
    d = q;
    ev = '0;
    clr = 1'b0;
    o_push = 1'b0;
    o_pop = 1'b0;
    r_push = 1'b0;
    r_pop = 1'b0;
    beat_done = 1'b0;
    d.drv_pulse = 1'b0;
    d.hready = 1'b1;
    d.hresp = 1'b0;
    d.wr_pend = 1'b0;
    d.rd_pend = 1'b0;

    // Reads take one wait state so a return value set by a call in the
    // previous transfer is already visible.
    if (q.rd_pend) begin
      d.hrdata = '0;
      if (q.hit) begin
        case (q.addr)
          OFF_ARG: d.hrdata = q.arg;
          OFF_RET: d.hrdata = q.ret;
          OFF_IRQ_STATUS: d.hrdata = 32'(q.irq_st);
          OFF_IRQ_MASK: d.hrdata = 32'(q.irq_mk);
          OFF_CONFIG: d.hrdata = 32'(q.latency);
          default: d.hrdata = '0;
        endcase
      end
    end
    if (hsel_in && hready_in && htrans_in == HTRANS_NONSEQ) begin
      d.addr = haddr_in[7:0];
      d.hit = haddr_in[31:8] == '0;
      if (hwrite_in) begin
        d.wr_pend = 1'b1;
      end else begin
        d.rd_pend = 1'b1;
        d.hready = 1'b0;
      end
    end

    // Stream side state machine.
    case (q.st)
      ST_IDLE: begin
        if (o_vld && r_rdy) begin
          o_pop = 1'b1; // [RL1] [RL17]
          d.cur = o_data;
          d.cnt = o_data.idles;
          d.stall = '0;
          d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (q.cnt == '0) begin
          d.st = ST_DRIVE;
          if (!q.latency) begin
            d.valid = 1'b1; // [RL14]
            d.drv_pulse = 1'b1; // [RL8]
          end
        end else begin
          d.cnt = q.cnt - 16'h0001; // [RL3]
        end
      end
      ST_DRIVE: begin
        if (q.latency ? q.valid : str_ready_in) begin
          beat_done = 1'b1;
        end else if (q.latency && str_ready_in) begin
          d.valid = 1'b1; // [RL15]
          d.drv_pulse = 1'b1; // [RL8]
        end else begin
          d.stall = q.stall + 16'h0001; // [RL16]
          if (q.tmo != '0 && d.stall >= q.tmo) begin
            d.st = ST_HALT; // [RL2] [RL10]
            d.valid = 1'b0;
            ev[IRQ_FATAL] = 1'b1;
          end
        end
        if (beat_done) begin
          d.valid = 1'b0;
          r_push = 1'b1; // [RL16] [RL17]
          ev[IRQ_RESP] = 1'b1; // [RL7]
          d.st = ST_IDLE;
          if (o_cnt == '0) begin
            ev[IRQ_DONE] = 1'b1; // [RL9]
            d.all_done = 1'b1;
          end
        end
      end
      ST_HALT: begin
        d.valid = 1'b0; // [RL10]
      end
      default: d.st = ST_IDLE;
    endcase
    if (d.drv_pulse) begin
      ev[IRQ_DRIVE] = 1'b1;
    end

    // Register writes land in the data phase.
    if (q.wr_pend && q.hit) begin
      case (q.addr)
        OFF_ARG: d.arg = hwdata_in;
        OFF_IRQ_STATUS: d.irq_st = q.irq_st & ~hwdata_in[IRQ_W-1:0];
        OFF_IRQ_MASK: d.irq_mk = hwdata_in[IRQ_W-1:0];
        OFF_CONFIG: d.latency = hwdata_in[CFG_LATENCY_BIT];
        OFF_CALL: begin
          // Calls decode the live hwdata_in in the data phase, and the
          // ready-state call samples str_ready_in as it stands. [RL11]
          case (hwdata_in[3:0]) // [RL12]
            CMD_INITIALISE: clr = q.st != ST_HALT; // [RL4] [RL10]
            CMD_SET_BACKPRESSURE_TIMEOUT: d.tmo = q.arg[15:0]; // [RL2]
            CMD_QUEUE_TRANSACTION: begin
              o_push = 1'b1; // [RL1]
              d.all_done = 1'b0;
            end
            CMD_READ_OUTGOING_DEPTH: d.ret = 32'(o_cnt);
            CMD_READ_RESPONSE_DEPTH: d.ret = 32'(r_cnt);
            // Field values are stored as given, legal or not. [RL5] [RL13]
            CMD_SET_BEAT_PAYLOAD: d.asm_t.data = q.arg;
            CMD_SET_BEAT_CHANNEL: d.asm_t.channel = q.arg[0];
            CMD_SET_LEADING_IDLES: d.asm_t.idles = q.arg[15:0]; // [RL3]
            CMD_SET_PACKET_FIRST: d.asm_t.sop = q.arg[0];
            CMD_SET_PACKET_LAST: d.asm_t.eop = q.arg[0];
            CMD_SET_BEAT_ERROR: d.asm_t.error = q.arg[0];
            CMD_SET_UNUSED_SYMBOLS: d.asm_t.empty = q.arg[1:0];
            CMD_TAKE_RESPONSE: begin
              r_pop = 1'b1; // [RL6] [RL17]
              if (r_vld) begin
                d.last_stall = r_data;
              end
            end
            CMD_READ_STALL_CYCLES: d.ret = 32'(q.last_stall); // [RL6]
            CMD_READ_READY_STATE: d.ret = 32'(str_ready_in);
            CMD_READ_ALL_DONE: d.ret = 32'(q.all_done);
            default: d.ret = q.ret;
          endcase
        end
        default: d.arg = q.arg;
      endcase
    end

    // Initialise wins over the stream machine, even over a same-cycle fatal halt whose event bit still sets, but not after a fatal halt.
    if (clr && q.st != ST_HALT) begin
      o_pop = 1'b0;
      r_push = 1'b0;
      ev[IRQ_DRIVE] = 1'b0;
      ev[IRQ_RESP] = 1'b0;
      ev[IRQ_DONE] = 1'b0;
      d.drv_pulse = 1'b0;
      d.st = ST_IDLE; // [RL4]
      d.valid = 1'b0;
      d.cur = '0;
      d.all_done = 1'b1;
    end

    // A new event beats a same-cycle write-one-to-clear.
    d.irq_st = d.irq_st | ev;
    d.irq = |(d.irq_st & d.irq_mk);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.tmo <= TIMEOUT_RESET;
      q.irq_mk <= MASK_RESET;
      q.all_done <= 1'b1;
      q.hready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign hrdata_out = q.hrdata;
  assign hreadyout_out = q.hready;
  assign hresp_out = q.hresp;
  assign str_valid_out = q.valid;
  assign str_data_out = q.cur.data;
  assign str_channel_out = q.cur.channel;
  assign str_sop_out = q.cur.sop;
  assign str_eop_out = q.cur.eop;
  assign str_empty_out = q.cur.empty;
  assign str_error_out = q.cur.error;
  assign irq_out = q.irq;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_hold;
    q.valid && !str_ready_in && !q.latency && !clr |=>
      q.st == ST_HALT || (q.valid && $stable(q.cur));
  endproperty
  a_hold: assert property (p_hold) else $error("beat dropped early"); // [RL14]

  property p_latency;
    q.latency && q.valid |-> $past(str_ready_in) ##1 !q.valid;
  endproperty
  a_latency: assert property (p_latency) else $error("latency beat bad"); // [RL15]

  property p_wait;
    q.st == ST_WAIT |-> !q.valid;
  endproperty
  a_wait: assert property (p_wait) else $error("valid during idles"); // [RL3]

  property p_idles;
    o_pop && !clr |=> q.cnt == $past(o_data.idles) && !q.valid;
  endproperty
  a_idles: assert property (p_idles) else $error("idle count lost"); // [RL3]

  property p_drive;
    $rose(q.valid) |-> q.drv_pulse && q.irq_st[IRQ_DRIVE];
  endproperty
  a_drive: assert property (p_drive) else $error("no driving event"); // [RL8]

  property p_init;
    clr && q.st != ST_HALT |=> !q.valid && q.st == ST_IDLE && q.cur == '0;
  endproperty
  a_init: assert property (p_init) else $error("init not idle"); // [RL4]

  property p_halt;
    q.st == ST_HALT |=> q.st == ST_HALT && !q.valid;
  endproperty
  a_halt: assert property (p_halt) else $error("halt left"); // [RL10]

  property p_timeout;
    q.st == ST_DRIVE && q.tmo != '0 |-> q.stall < q.tmo;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout missed"); // [RL2]

  property p_resp;
    beat_done && !clr && !r_pop |=>
      r_cnt == $past(r_cnt) + 4'h1 && q.irq_st[IRQ_RESP];
  endproperty
  a_resp: assert property (p_resp) else $error("response not queued"); // [RL7]

  property p_done;
    ev[IRQ_DONE] |-> o_cnt == '0 && beat_done;
  endproperty
  a_done: assert property (p_done) else $error("early completion"); // [RL9]

  c_fatal: cover property (q.st == ST_DRIVE ##1 q.st == ST_HALT);
  c_stall: cover property (q.valid && !str_ready_in ##1 q.valid);
  c_lat: cover property (q.latency && q.valid);
  c_done: cover property (ev[IRQ_DONE]);
endmodule

// >>> verification/stream_sink_model.sv
// Sink model that answers the stream driver with its ready line.
module stream_sink_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Behaviour: 0 always ready, 1 random stalls, 2 never ready
  input wire logic [1:0] mode_in,
  // Stream handshake
  output logic ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ready changes only after an edge, as a real sink register would.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_out <= 1'b0;
    end else begin
      case (mode_in)
        2'h0: ready_out <= 1'b1;
        2'h1: ready_out <= 1'($urandom_range(1));
        default: ready_out <= 1'b0;
      endcase
    end
  end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the stream source driver.
module tb_top
  import stream_source_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [1:0] pmode = 2'h0;
  logic [31:0] hrdata, data;
  logic hready, hresp, valid, ready, irq, ch, sop, eop, err;
  logic [1:0] emp;
  logic rd_ph = 1'b0;
  logic prv_rdy = 1'b0;
  logic cfg1 = 1'b0;
  int n_fail = 0;
  int cmp_count = 0;
  int stall = 0;
  logic [31:0] exp_rd[$];
  logic [37:0] exp_bt[$];
  logic [31:0] exp_st[$];
  wire [37:0] got_bt = {data, err, emp, eop, sop, ch};

  always #25 clk_in = ~clk_in;

  stream_source_driver stream_source_driver_i (
    .clk_in(clk_in), .rst_in(rst_in), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .str_valid_out(valid),
    .str_data_out(data), .str_channel_out(ch), .str_sop_out(sop),
    .str_eop_out(eop), .str_empty_out(emp), .str_error_out(err),
    .str_ready_in(ready), .irq_out(irq)
  );

  stream_sink_model stream_sink_model_i (
    .clk_in(clk_in), .rst_in(rst_in), .mode_in(pmode), .ready_out(ready)
  );

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp_beat(input logic [37:0] g, input logic [37:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic call(input logic [3:0] c, input logic [31:0] arg);
    wr(OFF_ARG, arg);
    wr(OFF_CALL, {28'h0, c});
  endtask

  task automatic ask(input logic [3:0] c, input logic [31:0] e);
    call(c, 32'h0);
    rd(OFF_RET, e);
  endtask

  task automatic take();
    call(CMD_TAKE_RESPONSE, 32'h0);
    ask(CMD_READ_STALL_CYCLES, exp_st.pop_front());
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Stall count is reckoned here from the wires, independent of the design.
  always @(posedge clk_in) begin
    if (hready === 1'b1) begin
      if (rd_ph && exp_rd.size() > 0) cmp_word(hrdata, exp_rd.pop_front());
      // The slave never signals an error, so every finished read is OKAY.
      if (rd_ph) cmp_word(32'(hresp), 32'h0);
      rd_ph <= htrans === HTRANS_NONSEQ && hwrite === 1'b0;
    end
    if (valid === 1'b1 && (cfg1 || ready === 1'b1)) begin
      // A beat nobody expected is compared with its own inverse to fail.
      cmp_beat(got_bt, exp_bt.size() > 0 ? exp_bt.pop_front()
               : ~got_bt);
      if (cfg1) cmp_word(32'(prv_rdy), 32'h1);
      exp_st.push_back(32'(stall));
      stall = 0;
    end else if (valid === 1'b1) begin
      stall++;
    end
    prv_rdy <= ready;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    end_sim();
  end

  initial begin
    logic [31:0] d;
    logic [5:0] f;
    int n;
    int dl[2];
    void'($urandom(17545));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(OFF_IRQ_STATUS, 32'h0);
    rd(OFF_IRQ_MASK, 32'(MASK_RESET));
    rd(OFF_CONFIG, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    ask(CMD_READ_ALL_DONE, 32'h1);
    ask(CMD_READ_READY_STATE, 32'h1);
    $display("test reset done");
    wr(OFF_IRQ_MASK, 32'hF);
    for (int i = 0; i < 2; i++) begin
      d = $urandom;
      f = 6'($urandom);
      call(CMD_SET_BEAT_PAYLOAD, d);
      call(CMD_SET_BEAT_CHANNEL, 32'(f[0]));
      call(CMD_SET_PACKET_FIRST, 32'(f[1]));
      call(CMD_SET_PACKET_LAST, 32'(f[2]));
      call(CMD_SET_UNUSED_SYMBOLS, 32'(f[4:3]));
      call(CMD_SET_BEAT_ERROR, 32'(f[5]));
      call(CMD_SET_LEADING_IDLES, 32'(i * 5));
      exp_bt.push_back({d, f});
      call(CMD_QUEUE_TRANSACTION, 32'h0);
      n = 0;
      while (valid !== 1'b1) begin
        @(posedge clk_in);
        n++;
      end
      dl[i] = n;
    end
    cmp_word(32'(dl[1] - dl[0]), 32'h5);
    repeat (2) @(posedge clk_in);
    rd(OFF_IRQ_STATUS, 32'h7);
    cmp_word(32'(irq), 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_in);
    cmp_word(32'(irq), 32'h0);
    wr(OFF_IRQ_STATUS, 32'hF);
    wr(OFF_IRQ_MASK, 32'hF);
    rd(OFF_IRQ_STATUS, 32'h0);
    cmp_word(32'(irq), 32'h0);
    repeat (2) take();
    $display("test fields done");
    pmode <= 2'h1;
    repeat (4) begin
      d = $urandom;
      call(CMD_SET_BEAT_PAYLOAD, d);
      exp_bt.push_back({d, f});
      call(CMD_QUEUE_TRANSACTION, 32'h0);
    end
    wait (exp_bt.size() == 0);
    @(posedge clk_in);
    ask(CMD_READ_OUTGOING_DEPTH, 32'h0);
    ask(CMD_READ_RESPONSE_DEPTH, 32'h4);
    repeat (4) take();
    $display("test order done");
    wr(OFF_IRQ_STATUS, 32'hF);
    pmode <= 2'h2;
    call(CMD_QUEUE_TRANSACTION, 32'h0);
    repeat (60) @(posedge clk_in);
    cmp_word(32'(valid), 32'h1);
    ask(CMD_READ_READY_STATE, 32'h0);
    rd(OFF_IRQ_STATUS, 32'h1);
    call(CMD_INITIALISE, 32'h0);
    repeat (2) @(posedge clk_in);
    stall = 0;
    cmp_word(32'(valid), 32'h0);
    ask(CMD_READ_ALL_DONE, 32'h1);
    ask(CMD_READ_RESPONSE_DEPTH, 32'h0);
    $display("test hold done");
    wr(OFF_CONFIG, 32'h1);
    cfg1 = 1'b1;
    pmode <= 2'h1;
    repeat (3) begin
      d = $urandom;
      call(CMD_SET_BEAT_PAYLOAD, d);
      exp_bt.push_back({d, f});
      call(CMD_QUEUE_TRANSACTION, 32'h0);
    end
    wait (exp_bt.size() == 0);
    @(posedge clk_in);
    wr(OFF_CONFIG, 32'h0);
    cfg1 = 1'b0;
    call(CMD_INITIALISE, 32'h0);
    exp_st.delete();
    $display("test latency done");
    wr(OFF_IRQ_STATUS, 32'hF);
    call(CMD_SET_BACKPRESSURE_TIMEOUT, 32'hA);
    pmode <= 2'h2;
    call(CMD_QUEUE_TRANSACTION, 32'h0);
    repeat (40) @(posedge clk_in);
    cmp_word(32'(valid), 32'h0);
    cmp_word(32'(irq), 32'h1);
    cmp_word(32'(stall), 32'hA);
    rd(OFF_IRQ_STATUS, 32'h9);
    pmode <= 2'h0;
    call(CMD_INITIALISE, 32'h0);
    call(CMD_QUEUE_TRANSACTION, 32'h0);
    repeat (20) @(posedge clk_in);
    cmp_word(32'(valid), 32'h0);
    stall = 0;
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(OFF_IRQ_STATUS, 32'h0);
    ask(CMD_READ_ALL_DONE, 32'h1);
    $display("test fatal done");
    end_sim();
  end
endmodule
